/* rtl/fbh_pkg.sv */
// Package for the parallel flash bus host: timing counts, register map, state and pin types
package fbh_pkg;

  // Clock period of sys_clk_in in ns
  localparam int CLK_NS = 8;

  // Flash bus times in ns (plain defaults, tune to the fitted part)
  localparam int T_SETUP_NS = 20;    // Address and data setup before write enable falls
  localparam int T_WP_NS = 50;       // Write enable low width
  localparam int T_HOLD_NS = 20;     // Data hold after write enable rises
  localparam int T_ACC_NS = 100;     // Chip select to valid read data
  localparam int T_RP_NS = 500;      // Reset pin low width
  localparam int T_RH_NS = 50;       // Reset high to first read
  localparam int T_READY_NS = 20000; // Longest internal reset recovery

  // Cycle counts, least times rounded up
  localparam int CNT_W = 12;
  localparam logic [11:0] CYC_SETUP = 12'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_WP = 12'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_HOLD = 12'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_ACC = 12'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_RP = 12'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_RH = 12'((T_RH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] CYC_READY = 12'((T_READY_NS + CLK_NS - 1) / CLK_NS);

  // Register offsets on the software port
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_ADDR = 4'h2;
  localparam logic [3:0] REG_WDATA = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;

  // Field positions
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_RESET_BIT = 2;
  localparam int CFG_BYTE_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_ABORT_BIT = 2;
  localparam int ST_TIMEOUT_BIT = 3;
  localparam int ST_SECTOR_LSB = 8;

  // Reset values
  localparam logic CFG_BYTE_RST = 1'b0;
  localparam logic [20:0] ADDR_RST = 21'h000000;
  localparam logic [15:0] WDATA_RST = 16'h0000;

  // Controller states, Gray codes along the write path; read and reset entry change several bits
  typedef enum logic [3:0] {
    FBH_IDLE = 4'h0,
    FBH_WR_SETUP = 4'h1,
    FBH_WR_PULSE = 4'h3,
    FBH_WR_HOLD = 4'h2,
    FBH_RD_ACC = 4'h6,
    FBH_RST_PULSE = 4'h7,
    FBH_RST_WAIT = 4'h5,
    FBH_RST_RECOV = 4'h4
  } fbh_state_t;

  // Flash pin bundle as driven by the host
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic rst_n;
    logic byte_n;
    logic [19:0] addr;
    logic [15:0] dq;
    logic [15:0] dq_oe_n;
  } fbh_pins_t;

endpackage

/* rtl/fbh_sector_dec.sv */
// Top-boot sector number decoder from the upper flash address bits
`timescale 1ns/1ps
module fbh_sector_dec
  import fbh_pkg::*;
(
  input wire logic [7:0] addr_hi_in,   // A19..A12
  output logic [5:0] sector_out        // Sector number 0..34
);

  // Only the bits that single out a sector are looked at
  always_comb begin
    if (addr_hi_in[7:3] != 5'h1f) begin
      // Large sectors: A19..A15 name the sector, A14..A12 unused
      sector_out = {1'b0, addr_hi_in[7:3]}; // R5 R6
    end else if (!addr_hi_in[2]) begin
      // Half-size sector below the boot area
      sector_out = 6'h1f; // R7
    end else if (!addr_hi_in[1]) begin
      // Two small parameter sectors picked by A12
      sector_out = {5'h10, addr_hi_in[0]}; // R8
    end else begin
      // Boot sector at the very top, A12 unused
      sector_out = 6'h22; // R9
    end
  end

endmodule

/* rtl/fbh_host.sv */
// Host controller that drives the parallel boot-sector flash through its pins
`timescale 1ns/1ps
// Behaviour
// R1: Writes: write enable, select low, output high
// R2: Program data width follows byte select pin
// R3: Fast mode programs in two writes
// R4: Erase one, several or all sectors
// R5: Sector chosen by upper address bits only
// R6: Sectors 0-30 decoded from A19-A15
// R7: Sector 31: A19-A15 ones, A14 zero
// R8: Sectors 32,33: A13 zero, A12 selects
// R9: Sector 34: A19-A13 all ones
// R10: Identifier mode reads codes on low byte
// R11: Busy reads return status on low byte
// R12: Select and reset high give standby
// R13: Wait access time after leaving standby
// R14: Deselect does not abort running operation
// R15: Output enable high floats data pins
// R16: Reset low aborts, floats, ignores accesses
// R17: Reset returns device to array read
// R18: Restart operations aborted by reset; host only sets the abort flag, no restart
// R19: Busy flag low until reset completes
// R20: Idle reset completes within recovery time
// R21: Wait reset-to-read delay after reset
// R22: Byte mode: high pin becomes address LSB
// R23: Power-up starts in array read
// R24: Address latched falling, data rising edge
module fbh_host
  import fbh_pkg::*;
(
  input wire logic sys_clk_in,           // 125 MHz system clock
  input wire logic rst_in,               // Asynchronous reset, active high
  input wire logic [3:0] reg_addr_in,    // Register offset
  input wire logic [31:0] reg_wdata_in,  // Register write data
  input wire logic reg_wr_in,            // Write strobe
  input wire logic reg_rd_in,            // Read strobe
  output logic [31:0] reg_rdata_out,     // Read data, one cycle after strobe
  output logic flash_ce_n_out,           // Chip select, active low
  output logic flash_oe_n_out,           // Output enable, active low
  output logic flash_we_n_out,           // Write enable, active low
  output logic flash_rst_n_out,          // Hardware reset, active low
  output logic flash_byte_n_out,         // Low selects byte width
  output logic [19:0] flash_addr_out,    // A19..A0
  output logic [15:0] flash_dq_out,      // Data pins, driven value
  output logic [15:0] flash_dq_oe_n_out, // Data pins, low while host drives
  input wire logic [15:0] flash_dq_in,   // Data pins, sensed value
  input wire logic op_done_flag_in       // Ready (1) or busy (0) from the flash
);

  // Pin bundle and its next value
  fbh_pins_t pins_ff;
  fbh_pins_t nxt_pins;

  // Sequencer state
  fbh_state_t state_ff;
  fbh_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;   // Cycles left in the current phase
  logic [CNT_W-1:0] nxt_cnt;

  // Software registers
  logic cfg_byte_ff;           // Byte width selected
  logic nxt_cfg_byte;
  logic [20:0] addr_ff;        // A19..A-1, bit 0 used only in byte width
  logic [20:0] nxt_addr;
  logic [15:0] wdata_ff;       // Data for the next bus write
  logic [15:0] nxt_wdata;
  logic [15:0] rdata_ff;       // Last data captured from the flash
  logic [15:0] nxt_rdata;
  logic abort_ff;              // Reset hit a running operation
  logic nxt_abort;
  logic timeout_ff;            // Flash never came ready after reset
  logic nxt_timeout;
  logic [31:0] rd_ff;          // Register read answer
  logic [31:0] nxt_rd;

  // Decoded sector of the programmed address
  logic [5:0] sector;

  // Decoder sees the address bits that pick a sector
  fbh_sector_dec u_sector_dec (
    .addr_hi_in(addr_ff[20:13]),
    .sector_out(sector)
  );

  // Software port decode
  logic wr_cmd;
  logic wr_status;
  logic idle;
  assign wr_cmd = reg_wr_in && (reg_addr_in == REG_CMD);
  assign wr_status = reg_wr_in && (reg_addr_in == REG_STATUS);
  assign idle = (state_ff == FBH_IDLE);

  // Configuration and data registers; ignored while a bus cycle runs
  always_comb begin
    nxt_cfg_byte = cfg_byte_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    if (reg_wr_in && idle) begin
      // Changing width mid-cycle would corrupt the pin meaning
      unique case (reg_addr_in)
        REG_CFG: begin
          nxt_cfg_byte = reg_wdata_in[CFG_BYTE_BIT]; // R2 R22
        end
        REG_ADDR: begin
          nxt_addr = reg_wdata_in[20:0];
        end
        REG_WDATA: begin
          nxt_wdata = reg_wdata_in[15:0];
        end
        default: begin
          nxt_addr = addr_ff;
        end
      endcase
    end
  end

  // Register read mux; data stand for one cycle only
  always_comb begin
    nxt_rd = 32'h00000000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        REG_CFG: begin
          nxt_rd[CFG_BYTE_BIT] = cfg_byte_ff;
        end
        REG_ADDR: begin
          nxt_rd[20:0] = addr_ff;
        end
        REG_WDATA: begin
          nxt_rd[15:0] = wdata_ff;
        end
        REG_RDATA: begin
          nxt_rd[15:0] = rdata_ff; // R10 R11
        end
        REG_STATUS: begin
          nxt_rd[ST_BUSY_BIT] = !idle;
          nxt_rd[ST_READY_BIT] = op_done_flag_in;
          nxt_rd[ST_ABORT_BIT] = abort_ff;
          nxt_rd[ST_TIMEOUT_BIT] = timeout_ff;
          nxt_rd[ST_SECTOR_LSB +: 6] = sector; // R5
        end
        default: begin
          nxt_rd = 32'h00000000;
        end
      endcase
    end
  end

  // Sequencer: one flash bus cycle or one reset pulse per command
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_pins = pins_ff;
    nxt_rdata = rdata_ff;
    nxt_abort = abort_ff;
    nxt_timeout = timeout_ff;
    nxt_pins.byte_n = !cfg_byte_ff; // R2
    // Software clears sticky flags by writing ones; a new event wins below
    if (wr_status) begin
      if (reg_wdata_in[ST_ABORT_BIT]) begin
        nxt_abort = 1'b0;
      end
      if (reg_wdata_in[ST_TIMEOUT_BIT]) begin
        nxt_timeout = 1'b0;
      end
    end
    if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
    unique case (state_ff)
      FBH_IDLE: begin
        // Standby: select and reset high, data pins released
        nxt_pins.ce_n = 1'b1; // R12
        nxt_pins.oe_n = 1'b1;
        nxt_pins.we_n = 1'b1;
        nxt_pins.rst_n = 1'b1;
        nxt_pins.dq_oe_n = 16'hffff;
        if (wr_cmd && reg_wdata_in[CMD_RESET_BIT]) begin
          // Reset has priority over bus cycles
          nxt_pins.rst_n = 1'b0; // R16 R17
          nxt_cnt = CYC_RP - 1'b1;
          nxt_state = FBH_RST_PULSE;
          if (!op_done_flag_in) begin
            nxt_abort = 1'b1; // R18
          end
        end else if (wr_cmd && reg_wdata_in[CMD_WRITE_BIT]) begin
          // Address and data set up before write enable falls
          nxt_pins.addr = addr_ff[20:1];
          nxt_pins.ce_n = 1'b0; // R1
          nxt_pins.dq = cfg_byte_ff ? {addr_ff[0], 7'h00, wdata_ff[7:0]} : wdata_ff; // R2 R22
          nxt_pins.dq_oe_n = cfg_byte_ff ? 16'h7f00 : 16'h0000; // R22
          nxt_cnt = CYC_SETUP - 1'b1;
          nxt_state = FBH_WR_SETUP;
        end else if (wr_cmd && reg_wdata_in[CMD_READ_BIT]) begin
          // Read: only the address LSB pin is driven in byte width
          nxt_pins.addr = addr_ff[20:1];
          nxt_pins.ce_n = 1'b0;
          nxt_pins.oe_n = 1'b0;
          nxt_pins.dq = {addr_ff[0], 15'h0000};
          nxt_pins.dq_oe_n = cfg_byte_ff ? 16'h7fff : 16'hffff; // R22
          nxt_cnt = CYC_ACC - 1'b1; // R13
          nxt_state = FBH_RD_ACC;
        end
      end
      FBH_WR_SETUP: begin
        if (cnt_ff == '0) begin
          // Falling write enable is the later edge: address taken here
          nxt_pins.we_n = 1'b0; // R1 R24
          nxt_cnt = CYC_WP - 1'b1;
          nxt_state = FBH_WR_PULSE;
        end
      end
      FBH_WR_PULSE: begin
        if (cnt_ff == '0) begin
          // Rising write enable is the earlier edge: data taken here
          nxt_pins.we_n = 1'b1; // R24
          nxt_cnt = CYC_HOLD - 1'b1;
          nxt_state = FBH_WR_HOLD;
        end
      end
      FBH_WR_HOLD: begin
        if (cnt_ff == '0) begin
          // Deselect is safe even if this write started an operation
          nxt_pins.ce_n = 1'b1; // R14
          nxt_pins.dq_oe_n = 16'hffff;
          nxt_state = FBH_IDLE;
        end
      end
      FBH_RD_ACC: begin
        if (cnt_ff == '0) begin
          // Full access time from select has passed; low byte only in byte width
          nxt_rdata = cfg_byte_ff ? {8'h00, flash_dq_in[7:0]} : flash_dq_in; // R10 R11
          nxt_pins.ce_n = 1'b1;
          nxt_pins.oe_n = 1'b1; // R15
          nxt_pins.dq_oe_n = 16'hffff;
          nxt_state = FBH_IDLE;
        end
      end
      FBH_RST_PULSE: begin
        if (cnt_ff == '0) begin
          // Release reset, then watch the busy flag for recovery
          nxt_pins.rst_n = 1'b1;
          nxt_cnt = CYC_READY - 1'b1;
          nxt_state = FBH_RST_WAIT;
        end
      end
      FBH_RST_WAIT: begin
        // Flag stays low while an interrupted operation winds down
        if (op_done_flag_in || cnt_ff == '0) begin
          if (!op_done_flag_in) begin
            nxt_timeout = 1'b1; // R19 R20
          end
          nxt_cnt = CYC_RH - 1'b1;
          nxt_state = FBH_RST_RECOV;
        end
      end
      FBH_RST_RECOV: begin
        // No access until the reset-to-read delay has passed
        if (cnt_ff == '0) begin
          nxt_state = FBH_IDLE; // R21 R23
        end
      end
      default: begin
        // Illegal code: fall back to standby
        nxt_pins.ce_n = 1'b1;
        nxt_pins.oe_n = 1'b1;
        nxt_pins.we_n = 1'b1;
        nxt_pins.rst_n = 1'b1;
        nxt_pins.dq_oe_n = 16'hffff;
        nxt_state = FBH_IDLE;
      end
    endcase
  end

  // All state registers
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= FBH_IDLE;
      cnt_ff <= '0;
      pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, byte_n: !CFG_BYTE_RST,
                   addr: 20'h00000, dq: 16'h0000, dq_oe_n: 16'hffff};
      cfg_byte_ff <= CFG_BYTE_RST;
      addr_ff <= ADDR_RST;
      wdata_ff <= WDATA_RST;
      rdata_ff <= 16'h0000;
      abort_ff <= 1'b0;
      timeout_ff <= 1'b0;
      rd_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      pins_ff <= nxt_pins;
      cfg_byte_ff <= nxt_cfg_byte;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      abort_ff <= nxt_abort;
      timeout_ff <= nxt_timeout;
      rd_ff <= nxt_rd;
    end
  end

  // Outputs straight from flops
  assign reg_rdata_out = rd_ff;
  assign flash_ce_n_out = pins_ff.ce_n;
  assign flash_oe_n_out = pins_ff.oe_n;
  assign flash_we_n_out = pins_ff.we_n;
  assign flash_rst_n_out = pins_ff.rst_n;
  assign flash_byte_n_out = pins_ff.byte_n;
  assign flash_addr_out = pins_ff.addr;
  assign flash_dq_out = pins_ff.dq;
  assign flash_dq_oe_n_out = pins_ff.dq_oe_n;

endmodule

/* test/fbh_host_assertions.sv */
// Checker on the flash pins of the bus host
`timescale 1ns/1ps
module fbh_host_assertions
  import fbh_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out,
  input wire logic flash_rst_n_out,
  input wire logic flash_byte_n_out,
  input wire logic [19:0] flash_addr_out,
  input wire logic [15:0] flash_dq_out,
  input wire logic [15:0] flash_dq_oe_n_out
);
  logic [11:0] we_cnt_ff, oe_cnt_ff, rp_cnt_ff; // Low cycles of each strobe
  logic [11:0] nxt_we_cnt, nxt_oe_cnt, nxt_rp_cnt;
  // Counters restart while their strobe is high
  always_comb begin
    nxt_we_cnt = flash_we_n_out ? 12'h000 : we_cnt_ff + 12'h001;
    nxt_oe_cnt = flash_oe_n_out ? 12'h000 : oe_cnt_ff + 12'h001;
    nxt_rp_cnt = flash_rst_n_out ? 12'h000 : rp_cnt_ff + 12'h001;
  end
  // Registers only
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      we_cnt_ff <= 12'h000;
      oe_cnt_ff <= 12'h000;
      rp_cnt_ff <= 12'h000;
    end else begin
      we_cnt_ff <= nxt_we_cnt;
      oe_cnt_ff <= nxt_oe_cnt;
      rp_cnt_ff <= nxt_rp_cnt;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wr_levels_a: assert property (!flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out)
    else $error("write strobe levels wrong");
  rd_release_a: assert property (!flash_oe_n_out |-> flash_dq_oe_n_out == {flash_byte_n_out, 15'h7fff} && flash_we_n_out)
    else $error("host drives data during read");
  byte_float_a: assert property (!flash_byte_n_out && !flash_ce_n_out |-> flash_dq_oe_n_out[14:8] == 7'h7f)
    else $error("middle data pins driven in byte width");
  rst_quiet_a: assert property (!flash_rst_n_out |-> flash_ce_n_out && flash_we_n_out && flash_oe_n_out)
    else $error("access during reset pulse");
  rst_width_a: assert property ($rose(flash_rst_n_out) |-> rp_cnt_ff == CYC_RP)
    else $error("reset pulse width wrong");
  wp_width_a: assert property ($rose(flash_we_n_out) |-> we_cnt_ff == CYC_WP)
    else $error("write pulse width wrong");
  latch_stable_a: assert property (!flash_we_n_out |-> $stable(flash_addr_out) && $stable(flash_dq_out))
    else $error("address or data moved in write pulse");
  data_hold_a: assert property ($rose(flash_we_n_out) |-> (!flash_ce_n_out && $stable(flash_dq_out))[*3])
    else $error("data not held after write pulse");
  acc_time_a: assert property ($rose(flash_oe_n_out) |-> oe_cnt_ff == CYC_ACC)
    else $error("read access time wrong");
  rh_gap_a: assert property ($rose(flash_rst_n_out) |-> flash_oe_n_out[*7])
    else $error("read too soon after reset");
  cover property ($rose(flash_we_n_out) && !flash_byte_n_out);
  cover property ($rose(flash_oe_n_out));
  cover property ($rose(flash_rst_n_out));
endmodule

/* test/fbh_flash_model.sv */
// Behavioural flash device on the host pins
`timescale 1ns/1ps
module fbh_flash_model
  import fbh_pkg::*;
#(
  parameter logic [15:0] INIT_WORD = 16'h3c96, // Array content before any program
  parameter logic [7:0] STAT_BYTE = 8'h4b, // Status pattern while busy
  parameter int BUSY_CYC = 200, // Program time in clocks
  parameter int RECOV_CYC = 100 // Reset recovery when busy
)
(
  input wire logic clk_in,
  input wire fbh_pins_t pins_in,
  output logic [15:0] dq_out,
  output logic [15:0] dq_en_out,
  output logic done_out,
  output logic [15:0] got_data_out,
  output logic [20:0] got_addr_out
);
  logic [15:0] mem = INIT_WORD; // One-word array
  logic we_q = 1'b1;
  logic rst_q = 1'b1;
  logic ab = 1'b0; // Pending program cut off by reset
  int busy_cnt = 0;
  logic drv;
  assign drv = !pins_in.ce_n && !pins_in.oe_n && pins_in.rst_n;
  assign dq_en_out = !drv ? 16'h0000 : pins_in.byte_n ? 16'hffff : 16'h00ff;
  assign dq_out = (busy_cnt != 0) ? {8'h00, STAT_BYTE} : mem; // not modelled
  assign done_out = (busy_cnt == 0);
  // Host pins come from flops, so its clock sees every pin edge
  always @(posedge clk_in) begin
    we_q <= pins_in.we_n;
    rst_q <= pins_in.rst_n;
    if (busy_cnt != 0) busy_cnt <= busy_cnt - 1; // select not looked at
    if (busy_cnt == 1 && !ab) mem <= got_data_out;
    if (!pins_in.rst_n) begin // writes ignored
      if (rst_q && busy_cnt != 0) begin
        busy_cnt <= RECOV_CYC;
        ab <= 1'b1;
      end
    end else if (!pins_in.ce_n && pins_in.oe_n) begin
      if (!pins_in.we_n && we_q) got_addr_out <= {pins_in.addr, pins_in.byte_n ? 1'b0 : pins_in.dq[15]};
      if (pins_in.we_n && !we_q) begin
        got_data_out <= pins_in.byte_n ? pins_in.dq : {8'h00, pins_in.dq[7:0]};
        busy_cnt <= BUSY_CYC;
        ab <= 1'b0;
      end
    end
  end
endmodule

/* test/test_fbh_host.sv */
// Self-checking bench for the flash bus host
`timescale 1ns/1ps
module test_fbh_host;
  import fbh_pkg::*;
  localparam logic [15:0] INIT_WORD = 16'h3c96;
  localparam logic [7:0] STAT_BYTE = 8'h4b;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out, rd_val;
  wire fbh_pins_t pins; // Host pin bundle
  logic [15:0] dq_in, mdl_dq, mdl_en, got_data;
  logic [20:0] got_addr;
  logic mdl_done;
  logic flt_ff = 1'b0; // Level of a floating pin
  int err_total = 0;
  int num_checks = 0;
  int n_we = 0; // Write pulses seen on the pins
  int n0; // Pulse count before a scenario
  logic we_d = 1'b1; // Write enable one clock back
  logic [7:0] row_hi [11] = '{8'h00, 8'h07, 8'h08, 8'hf0, 8'hf7, 8'hf8, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
  logic [5:0] row_sec [11] = '{6'h00, 6'h00, 6'h01, 6'h1e, 6'h1e, 6'h1f, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h22};
  always #4 sys_clk_in = ~sys_clk_in;
  // Floating pins toggle so a stale level never passes for data
  always @(posedge sys_clk_in) flt_ff <= ~flt_ff;
  // Count falling write enable edges, one per bus write cycle
  always @(posedge sys_clk_in) begin
    we_d <= pins.we_n;
    if (we_d && !pins.we_n) n_we++;
  end
  assign dq_in = (~pins.dq_oe_n & pins.dq) | (mdl_en & mdl_dq) | (pins.dq_oe_n & ~mdl_en & {16{flt_ff}});
  fbh_host dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .flash_ce_n_out(pins.ce_n),
    .flash_oe_n_out(pins.oe_n), .flash_we_n_out(pins.we_n), .flash_rst_n_out(pins.rst_n),
    .flash_byte_n_out(pins.byte_n), .flash_addr_out(pins.addr), .flash_dq_out(pins.dq),
    .flash_dq_oe_n_out(pins.dq_oe_n), .flash_dq_in(dq_in), .op_done_flag_in(mdl_done));
  // Recovery longer than the host's wait, so the timeout path is taken
  fbh_flash_model #(.INIT_WORD(INIT_WORD), .STAT_BYTE(STAT_BYTE), .RECOV_CYC(3000)) mdl (.clk_in(sys_clk_in), .pins_in(pins),
    .dq_out(mdl_dq), .dq_en_out(mdl_en), .done_out(mdl_done), .got_data_out(got_data), .got_addr_out(got_addr));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 rd_val = reg_rdata_out;
  endtask
  // Bounded wait for a status bit
  task automatic poll(input int b, input logic want);
    int n;
    n = 0;
    rd(REG_STATUS);
    while (rd_val[b] !== want && n < 4000) begin
      rd(REG_STATUS);
      n++;
    end
    if (n == 4000) chk("status poll", {31'h0, want}, {31'h0, rd_val[b]});
  endtask
  task automatic cmd(input logic [31:0] c);
    wr(REG_CMD, c);
    poll(ST_BUSY_BIT, 1'b0);
  endtask
  task automatic complete_run();
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog, far beyond the expected run
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    // Sector number at each boundary, low address bits all ones
    for (int i = 0; i < 11; i++) begin
      wr(REG_ADDR, {11'h0, row_hi[i], 13'h1fff});
      rd(REG_STATUS);
      chk("sector", {26'h0, row_sec[i]}, {26'h0, rd_val[13:8]});
    end
    // Second reset in mid-run
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    rd(REG_ADDR);
    chk("addr reset", 32'h0, rd_val);
    chk("idle pins", 32'h1f, {27'h0, pins.ce_n, pins.oe_n, pins.we_n, pins.rst_n, pins.byte_n});
    rd(4'hf);
    chk("unmapped", 32'h0, rd_val);
    cmd(32'h2);
    rd(REG_RDATA);
    chk("array read", {16'h0, INIT_WORD}, rd_val);
    // Word program, then read while the device is still busy
    wr(REG_ADDR, 32'h000b4b4a);
    wr(REG_WDATA, 32'h0000c3e1);
    cmd(32'h1);
    chk("word data", 32'h0000c3e1, {16'h0, got_data});
    chk("word addr", 32'h000b4b4a, {11'h0, got_addr});
    cmd(32'h2);
    rd(REG_RDATA);
    chk("status byte", {24'h0, STAT_BYTE}, {24'h0, rd_val[7:0]});
    rd(REG_STATUS);
    chk("busy deselected", 32'h0, {31'h0, rd_val[ST_READY_BIT]});
    poll(ST_READY_BIT, 1'b1);
    // Shortened program sequence: two plain bus writes, one pulse each
    n0 = n_we;
    cmd(32'h1);
    cmd(32'h1);
    chk("fast writes", n0 + 2, n_we);
    poll(ST_READY_BIT, 1'b1);
    // Byte width program and read, A-1 on the top data pin
    wr(REG_CFG, 32'h1);
    wr(REG_ADDR, 32'h00000247);
    wr(REG_WDATA, 32'h000012a5);
    cmd(32'h1);
    chk("byte data", 32'h000000a5, {16'h0, got_data});
    chk("byte addr", 32'h00000247, {11'h0, got_addr});
    chk("byte pin", 32'h0, {31'h0, pins.byte_n});
    poll(ST_READY_BIT, 1'b1);
    cmd(32'h2);
    rd(REG_RDATA);
    chk("byte read", 32'h000000a5, rd_val);
    // Reset in mid-program discards the word
    wr(REG_CFG, 32'h0);
    wr(REG_WDATA, 32'h00007e18);
    cmd(32'h1);
    cmd(32'h4);
    rd(REG_STATUS);
    chk("abort flag", 32'h1, {31'h0, rd_val[ST_ABORT_BIT]});
    chk("timeout flag", 32'h1, {31'h0, rd_val[ST_TIMEOUT_BIT]});
    poll(ST_READY_BIT, 1'b1);
    cmd(32'h2);
    rd(REG_RDATA);
    chk("after abort", 32'h000000a5, rd_val);
    // Reset while idle
    wr(REG_STATUS, 32'hc);
    cmd(32'h4);
    rd(REG_STATUS);
    chk("idle reset", 32'h0, {31'h0, rd_val[ST_ABORT_BIT]});
    chk("idle timeout", 32'h0, {31'h0, rd_val[ST_TIMEOUT_BIT]});
    complete_run();
  end
endmodule
bind fbh_host fbh_host_assertions chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .flash_ce_n_out(flash_ce_n_out),
  .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out), .flash_rst_n_out(flash_rst_n_out),
  .flash_byte_n_out(flash_byte_n_out), .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_n_out(flash_dq_oe_n_out));
